// ==== rtl/tec_pkg.sv ====
// Package: constants, register map and types of the trigger and exposure block
package tec_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYC = US_NS / CLK_PERIOD_NS;
  localparam int unsigned NOTIFY_US = 10;
  localparam int unsigned NOTIFY_CYC = NOTIFY_US * US_NS / CLK_PERIOD_NS;
  localparam int unsigned TS_MHZ = 60;
  localparam int unsigned GLITCH_MIN_NS = 90;
  localparam int unsigned GLITCH_MIN_CYC =
    (GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_MAX_NS = 2000000;
  localparam int unsigned GLITCH_MAX_CYC = GLITCH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DELAY_MAX_US = 200000;
  localparam int unsigned EXPOSE_MIN_US = 10;
  localparam int unsigned EXPOSE_MAX_US = 1000000;
  localparam int unsigned LEVEL_EXTRA_CYC = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SWTRIG = 8'h04;
  localparam logic [7:0] OFS_EXPOSE = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0c;
  localparam logic [7:0] OFS_GLITCH = 8'h10;
  localparam logic [7:0] OFS_READOUT = 8'h14;
  localparam logic [7:0] OFS_TIMER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  localparam logic [7:0] OFS_TSTAMP = 8'h28;
  localparam logic [7:0] OFS_EVTS = 8'h40;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] CTRL_RST = 5'h08;
  localparam logic [19:0] EXPOSE_RST = 20'h003e8;
  localparam logic [17:0] DELAY_RST = 18'h0;
  localparam logic [17:0] GLITCH_RST = 18'(GLITCH_MIN_CYC);
  localparam logic [19:0] READOUT_RST = 20'h003e8;
  localparam logic [17:0] TIMER_RST = 18'h0;

  // ****************************************
  // Event bit positions
  // ****************************************
  localparam int unsigned NUM_EV = 9;
  localparam int unsigned EV_ACC = 0;
  localparam int unsigned EV_REJ = 1;
  localparam int unsigned EV_WAIT = 2;
  localparam int unsigned EV_XBEG = 3;
  localparam int unsigned EV_XEND = 4;
  localparam int unsigned EV_EBEG = 5;
  localparam int unsigned EV_EEND = 6;
  localparam int unsigned EV_TBEG = 7;
  localparam int unsigned EV_TEND = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SRC_LINE, SRC_SOFT, SRC_LINK} tec_src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_EXPOSE} tec_state_e;

  typedef struct packed {
    logic line_inv;
    logic enable;
    logic level_mode;
    tec_src_e src;
  } tec_ctrl_s;

endpackage : tec_pkg

// ==== rtl/tec_glitch_filter.sv ====
// Glitch filter for the synchronised external trigger level
`timescale 1ns/10ps
`default_nettype none
module tec_glitch_filter #(
  parameter int unsigned CW = 18
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Level in, window in cycles, filtered level out
  input wire logic din,
  input wire logic [CW-1:0] win,
  output logic dout
);

  logic [CW-1:0] cnt;
  logic differ;
  logic expired;

  assign differ = din != dout;
  assign expired = cnt >= (win - CW'(1));

  // Output follows only after the input held its new level for win cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      dout <= 1'b0;
    end else if (!differ) begin
      cnt <= '0;
    end else if (expired) begin // see RULE_10
      cnt <= '0;
      dout <= din;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  glitch_hold_a: assert property ( // see RULE_10
    @(posedge sys_clk) disable iff (!arst_n)
    $changed(dout) |-> ($past(cnt) >= $past(win) - CW'(1)))
    else $error("filter output changed before the window ran out");

endmodule : tec_glitch_filter
`default_nettype wire

// ==== rtl/tec_trigger_ctrl.sv ====
// Trigger acceptance, exposure sequencing, events and timestamps
// Function
// RULE_01: During readout, drop triggers whose exposure would end inside it.
// RULE_02: Trigger source must not trigger while the wait output is low.
// RULE_03: Level-mode exposure outlasts the trigger pulse by a fixed tail.
// RULE_04: Each event is notified about 10 us after it happens.
// RULE_05: Event timestamp counter advances at 60 MHz.
// RULE_06: Nine distinct events, each tagged with the timestamp.
// RULE_07: Trigger comes from line input, software command or link packet.
// RULE_08: Edge mode uses programmed exposure; level mode follows pulse width.
// RULE_09: Programmable trigger delay 0 to 200000 us, default zero.
// RULE_10: Line trigger glitch window 90 ns to 2 ms, default 90 ns; code clamps to 12 to 250000 cycles, default 12 cycles (96 ns).
`timescale 1ns/10ps
`default_nettype none
module tec_trigger_ctrl #(
  parameter int unsigned DLY_MAX_US = tec_pkg::DELAY_MAX_US,
  parameter int unsigned EXP_MAX_US = tec_pkg::EXPOSE_MAX_US,
  parameter int unsigned GLITCH_MAX = tec_pkg::GLITCH_MAX_CYC,
  parameter int unsigned LEVEL_EXTRA = tec_pkg::LEVEL_EXTRA_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire logic trig_line,
  input wire logic link_trig,
  // Status outputs
  output logic awaiting_trigger,
  output logic exposure_active,
  output logic transfer_active,
  output logic aux_timer_active,
  output logic irq
);

  localparam int unsigned NE = tec_pkg::NUM_EV;

  function automatic logic [31:0] clamp_val(input logic [31:0] v,
                                            input logic [31:0] lo,
                                            input logic [31:0] hi);
    clamp_val = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_val

  // ****************************************
  // Registers and state
  // ****************************************
  tec_pkg::tec_ctrl_s ctrl;
  logic [19:0] exp_us;
  logic [17:0] dly_us;
  logic [17:0] glitch_win;
  logic [19:0] rd_us;
  logic [17:0] tmr_us;
  logic [NE-1:0] status;
  logic [NE-1:0] mask;
  tec_pkg::tec_state_e state;
  tec_pkg::tec_state_e next_state;
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic lvl_run;
  logic [19:0] rd_cnt;
  logic [17:0] tmr_cnt;
  logic [6:0] div;
  logic [6:0] ts_acc;
  logic [31:0] tstamp;
  logic line_s1;
  logic line_s2;
  logic filt;
  logic filt_d;
  logic sw_pulse;
  logic [NE-1:0] pend;
  logic [10:0] ncnt [NE];
  logic [31:0] ev_ts [NE];

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic wr_en;
  logic [NE-1:0] fire;
  logic [NE-1:0] w1c;
  logic ev_hit;
  logic reg_hit;
  logic [31:0] rd_mux;
  logic [3:0] ev_idx;

  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign ev_idx = paddr[5:2];
  assign ev_hit = (paddr[7:6] == 2'h1) && (ev_idx < 4'(NE));
  assign w1c = (wr_en && paddr == tec_pkg::OFS_STATUS) ?
               pwdata[NE-1:0] : '0;
  assign reg_hit = ev_hit || (paddr <= tec_pkg::OFS_TSTAMP);
  assign rd_mux =
    (paddr == tec_pkg::OFS_CTRL) ? {27'h0, ctrl} :
    (paddr == tec_pkg::OFS_EXPOSE) ? {12'h0, exp_us} :
    (paddr == tec_pkg::OFS_DELAY) ? {14'h0, dly_us} :
    (paddr == tec_pkg::OFS_GLITCH) ? {14'h0, glitch_win} :
    (paddr == tec_pkg::OFS_READOUT) ? {12'h0, rd_us} :
    (paddr == tec_pkg::OFS_TIMER) ? {14'h0, tmr_us} :
    (paddr == tec_pkg::OFS_STATUS) ? {23'h0, status} :
    (paddr == tec_pkg::OFS_MASK) ? {23'h0, mask} :
    (paddr == tec_pkg::OFS_STATE) ?
      {28'h0, awaiting_trigger, rd_cnt != 20'h0, state} :
    (paddr == tec_pkg::OFS_TSTAMP) ? tstamp :
    ev_hit ? ev_ts[ev_idx] : 32'h0;

  // One wait state: data and pready registered, writes land on completion
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      prdata <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= access & ~pready & ~reg_hit;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= tec_pkg::tec_ctrl_s'(tec_pkg::CTRL_RST);
      exp_us <= tec_pkg::EXPOSE_RST;
      dly_us <= tec_pkg::DELAY_RST;
      glitch_win <= tec_pkg::GLITCH_RST;
      rd_us <= tec_pkg::READOUT_RST;
      tmr_us <= tec_pkg::TIMER_RST;
      mask <= '0;
      sw_pulse <= 1'b0;
    end else begin
      sw_pulse <= wr_en && paddr == tec_pkg::OFS_SWTRIG && pwdata[0];
      if (wr_en) begin
        unique case (paddr)
          tec_pkg::OFS_CTRL: ctrl <= tec_pkg::tec_ctrl_s'(pwdata[4:0]);
          tec_pkg::OFS_EXPOSE: exp_us <= 20'(clamp_val(pwdata,
            tec_pkg::EXPOSE_MIN_US, EXP_MAX_US));
          tec_pkg::OFS_DELAY: dly_us <= 18'(clamp_val(pwdata, 32'h0,
            DLY_MAX_US)); // see RULE_09
          tec_pkg::OFS_GLITCH: glitch_win <= 18'(clamp_val(pwdata,
            tec_pkg::GLITCH_MIN_CYC, GLITCH_MAX)); // see RULE_10
          tec_pkg::OFS_READOUT: rd_us <= pwdata[19:0];
          tec_pkg::OFS_TIMER: tmr_us <= pwdata[17:0];
          tec_pkg::OFS_MASK: mask <= pwdata[NE-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Time bases: microsecond tick, 60 MHz stamp
  // ****************************************
  logic us_tick;
  logic [7:0] ts_sum;
  logic ts_tick;

  assign us_tick = div == 7'(tec_pkg::US_CYC - 1);
  assign ts_sum = {1'h0, ts_acc} + 8'(tec_pkg::TS_MHZ);
  assign ts_tick = ts_sum >= 8'(tec_pkg::CLK_MHZ);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 7'h0;
      ts_acc <= 7'h0;
      tstamp <= 32'h0;
    end else begin
      div <= us_tick ? 7'h0 : div + 7'h1;
      ts_acc <= ts_tick ? 7'(ts_sum - 8'(tec_pkg::CLK_MHZ)) : ts_sum[6:0];
      if (ts_tick) begin
        tstamp <= tstamp + 32'h1; // see RULE_05
      end
    end
  end

  // ****************************************
  // Trigger source and acceptance
  // ****************************************
  logic line_rise;
  logic trig_any;
  logic lvl_mode;
  logic rd_busy;
  logic [20:0] need_us;
  logic trig_ok;
  logic take;
  logic reject;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
      filt_d <= 1'b0;
    end else begin
      line_s1 <= trig_line;
      line_s2 <= line_s1;
      filt_d <= filt;
    end
  end

  tec_glitch_filter #(.CW(18)) u_filter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(line_s2 ^ ctrl.line_inv),
    .win(glitch_win),
    .dout(filt)
  );

  assign line_rise = filt & ~filt_d;
  assign trig_any = ctrl.enable & (
    (ctrl.src == tec_pkg::SRC_LINE) ? line_rise :
    (ctrl.src == tec_pkg::SRC_SOFT) ? sw_pulse :
    (ctrl.src == tec_pkg::SRC_LINK) ? link_trig : 1'b0); // see RULE_07
  assign lvl_mode = ctrl.level_mode &
                    (ctrl.src == tec_pkg::SRC_LINE); // see RULE_08
  assign rd_busy = rd_cnt != 20'h0;
  assign need_us = {3'h0, dly_us} + {1'h0, exp_us};
  assign trig_ok = (state == tec_pkg::ST_IDLE) &&
    (!rd_busy || (!lvl_mode && need_us >= {1'h0, rd_cnt})); // see RULE_01
  assign take = trig_any & trig_ok;
  assign reject = trig_any & ~trig_ok; // see RULE_02

  // ****************************************
  // Exposure sequencer
  // ****************************************
  logic lvl_sel;
  logic [19:0] exp_load;

  assign lvl_sel = (state == tec_pkg::ST_IDLE) ? lvl_mode : lvl_run;
  assign exp_load = lvl_sel ? 20'(LEVEL_EXTRA) : exp_us; // see RULE_08

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      tec_pkg::ST_IDLE: begin
        if (take && dly_us == 18'h0) begin
          next_state = tec_pkg::ST_EXPOSE;
          next_cnt = exp_load;
        end else if (take) begin
          next_state = tec_pkg::ST_DELAY; // see RULE_09
          next_cnt = {2'h0, dly_us};
        end
      end
      tec_pkg::ST_DELAY: begin
        if (us_tick && cnt == 20'h1) begin
          next_state = tec_pkg::ST_EXPOSE;
          next_cnt = exp_load;
        end else if (us_tick) begin
          next_cnt = cnt - 20'h1;
        end
      end
      tec_pkg::ST_EXPOSE: begin
        if (lvl_run && filt) begin
          next_cnt = 20'(LEVEL_EXTRA); // see RULE_03
        end else if ((lvl_run || us_tick) && cnt <= 20'h1) begin
          next_state = tec_pkg::ST_IDLE;
          next_cnt = 20'h0;
        end else if (lvl_run || us_tick) begin
          next_cnt = cnt - 20'h1;
        end
      end
    endcase
  end

  // ****************************************
  // Events
  // ****************************************
  logic next_wait;
  logic [NE-1:0] ev_now;
  logic exp_beg;
  logic exp_end;
  logic xfer_end;
  logic tmr_end;

  assign next_wait = (next_state == tec_pkg::ST_IDLE) & ctrl.enable;
  assign exp_beg = next_state == tec_pkg::ST_EXPOSE &&
                   state != tec_pkg::ST_EXPOSE;
  assign exp_end = state == tec_pkg::ST_EXPOSE &&
                   next_state != tec_pkg::ST_EXPOSE;
  assign xfer_end = rd_busy && us_tick && rd_cnt == 20'h1 && !exp_end;
  assign tmr_end = tmr_cnt != 18'h0 && us_tick && tmr_cnt == 18'h1;
  assign ev_now = {tmr_end, take && tmr_us != 18'h0, exp_end, exp_beg,
                   xfer_end, exp_end && rd_us != 20'h0,
                   next_wait & ~awaiting_trigger, reject, take}; // see RULE_06

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= tec_pkg::ST_IDLE;
      cnt <= 20'h0;
      lvl_run <= 1'b0;
      rd_cnt <= 20'h0;
      tmr_cnt <= 18'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lvl_run <= (state == tec_pkg::ST_IDLE) ? lvl_mode : lvl_run;
      if (exp_end) begin
        rd_cnt <= rd_us;
      end else if (rd_busy && us_tick) begin
        rd_cnt <= rd_cnt - 20'h1;
      end
      if (take) begin
        tmr_cnt <= tmr_us;
      end else if (tmr_cnt != 18'h0 && us_tick) begin
        tmr_cnt <= tmr_cnt - 18'h1;
      end
    end
  end

  // ****************************************
  // Delayed notification and interrupt
  // ****************************************
  genvar gi;
  for (gi = 0; gi < NE; gi++) begin : g_fire
    assign fire[gi] = pend[gi] && ncnt[gi] == 11'h0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= '0;
      status <= '0;
      for (int i = 0; i < NE; i++) begin
        ncnt[i] <= 11'h0;
        ev_ts[i] <= 32'h0;
      end
    end else begin
      status <= (status & ~w1c) | fire;
      for (int i = 0; i < NE; i++) begin
        if (ev_now[i]) begin
          pend[i] <= 1'b1;
          ncnt[i] <= 11'(tec_pkg::NOTIFY_CYC - 1); // see RULE_04
          ev_ts[i] <= tstamp; // see RULE_06
        end else if (fire[i]) begin
          pend[i] <= 1'b0;
        end else if (pend[i]) begin
          ncnt[i] <= ncnt[i] - 11'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awaiting_trigger <= 1'b0;
      exposure_active <= 1'b0;
      transfer_active <= 1'b0;
      aux_timer_active <= 1'b0;
      irq <= 1'b0;
    end else begin
      awaiting_trigger <= next_wait;
      exposure_active <= next_state == tec_pkg::ST_EXPOSE;
      transfer_active <= exp_end ? rd_us != 20'h0 : rd_busy && !xfer_end;
      aux_timer_active <= take ? tmr_us != 18'h0 :
                          tmr_cnt != 18'h0 && !tmr_end;
      irq <= |(((status & ~w1c) | fire) & mask);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  readout_fit_a: assert property ( // see RULE_01
    @(posedge sys_clk) disable iff (!arst_n)
    (trig_any && state == tec_pkg::ST_IDLE && rd_busy &&
     (lvl_mode || need_us < {1'h0, rd_cnt})) |=>
    (state == tec_pkg::ST_IDLE && !exposure_active))
    else $error("trigger taken whose exposure ends inside readout");

  busy_reject_a: assert property ( // see RULE_02
    @(posedge sys_clk) disable iff (!arst_n)
    (trig_any && state != tec_pkg::ST_IDLE) |-> ev_now[tec_pkg::EV_REJ] ##1
    (state != tec_pkg::ST_IDLE || $past(state) == tec_pkg::ST_EXPOSE))
    else $error("trigger while busy was not rejected");

  level_tail_a: assert property ( // see RULE_03
    @(posedge sys_clk) disable iff (!arst_n)
    ($fell(filt) && lvl_run && state == tec_pkg::ST_EXPOSE) |->
    exposure_active [*8])
    else $error("level exposure ended with the trigger pulse");

  notify_load_a: assert property ( // see RULE_04
    @(posedge sys_clk) disable iff (!arst_n)
    ev_now[tec_pkg::EV_ACC] |=>
    pend[tec_pkg::EV_ACC] && ncnt[tec_pkg::EV_ACC] == 11'h4e1)
    else $error("notification countdown not loaded");

  notify_fire_a: assert property ( // see RULE_04
    @(posedge sys_clk) disable iff (!arst_n)
    (fire[tec_pkg::EV_EBEG] && !ev_now[tec_pkg::EV_EBEG]) |=>
    status[tec_pkg::EV_EBEG] && !pend[tec_pkg::EV_EBEG])
    else $error("expired notification did not set status");

  stamp_rate_a: assert property ( // see RULE_05
    @(posedge sys_clk) disable iff (!arst_n)
    ts_tick |=> !ts_tick ##1 (ts_tick or (!ts_tick ##1 ts_tick)))
    else $error("timestamp tick spacing is not 60 MHz");

  stamp_step_a: assert property ( // see RULE_05
    @(posedge sys_clk) disable iff (!arst_n)
    ts_tick |=> tstamp == $past(tstamp) + 32'h1)
    else $error("timestamp did not advance by one");

  expose_event_a: assert property ( // see RULE_06
    @(posedge sys_clk) disable iff (!arst_n)
    ev_now[tec_pkg::EV_EEND] |=> !exposure_active &&
    ev_ts[tec_pkg::EV_EEND] == $past(tstamp))
    else $error("exposure end event not tagged");

  source_sel_a: assert property ( // see RULE_07
    @(posedge sys_clk) disable iff (!arst_n)
    (ctrl.src == tec_pkg::SRC_LINK && !link_trig) |-> !trig_any)
    else $error("trigger from an unselected source");

  zero_delay_a: assert property ( // see RULE_09
    @(posedge sys_clk) disable iff (!arst_n)
    (take && dly_us == 18'h0) |=> state == tec_pkg::ST_EXPOSE &&
    exposure_active)
    else $error("zero delay did not expose at once");

endmodule : tec_trigger_ctrl
`default_nettype wire

// ==== testbench/tec_trig_source.sv ====
// Model of the external trigger source and the link trigger decoder
`timescale 1ns/10ps
`default_nettype none
module tec_trig_source (
  // Clock
  input wire logic sys_clk,
  // Device status
  input wire logic awaiting_trigger,
  // Trigger outputs
  output logic trig_line,
  output logic link_trig
);
  // ****************************************
  // Trigger tasks
  // ****************************************
  initial begin
    trig_line = 1'b0;
    link_trig = 1'b0;
  end

  // A new trigger waits up to 20000 cycles for the device to wait for one
  task automatic hold_for_wait(input int gap);
    int i;
    repeat (gap) @(posedge sys_clk);
    for (i = 0; i < 20000; i++) begin
      if (awaiting_trigger === 1'b1) break;
      @(posedge sys_clk);
    end
  endtask : hold_for_wait

  // One-cycle pulse from the link packet decoder after gap cycles
  task automatic link_pulse(input int gap);
    hold_for_wait(gap);
    link_trig <= 1'b1;
    @(posedge sys_clk);
    link_trig <= 1'b0;
  endtask : link_pulse

  // Line level change; a rise waits for the device to be ready
  task automatic line_set(input logic lvl);
    if (lvl) begin
      hold_for_wait(0);
    end
    trig_line <= lvl;
    @(posedge sys_clk);
  endtask : line_set
endmodule : tec_trig_source
`default_nettype wire

// ==== testbench/test_trigger_exposure_event_control.sv ====
// Self-checking bench of the trigger and exposure controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module test_trigger_exposure_event_control;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [31:0] t0;
  logic pready, pslverr, e, trig_line, link_trig, awaiting_trigger;
  logic exposure_active, transfer_active, aux_timer_active, irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  int n1;
  int d;

  always #4 sys_clk = ~sys_clk;

  tec_trigger_ctrl tec_trigger_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_line(trig_line), .link_trig(link_trig),
    .awaiting_trigger(awaiting_trigger), .exposure_active(exposure_active),
    .transfer_active(transfer_active), .aux_timer_active(aux_timer_active),
    .irq(irq));
  tec_trig_source tec_trig_source_i (.sys_clk(sys_clk),
    .awaiting_trigger(awaiting_trigger), .trig_line(trig_line),
    .link_trig(link_trig));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      `CHK("pready", 1'b1, 1'b0)
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask : rdc

  // Cycles until exposure_active (s=0) or irq (s=1) reaches lvl
  task automatic wt(input int s, input logic lvl, input int lim);
    n = 0;
    while (((s == 0) ? exposure_active : irq) !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wt

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #800000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdc("ctrl", tec_pkg::OFS_CTRL, 32'h08);
    rdc("expose", tec_pkg::OFS_EXPOSE, 32'h3e8);
    rdc("delay", tec_pkg::OFS_DELAY, 32'h0);
    rdc("glitch", tec_pkg::OFS_GLITCH, 32'hc);
    rdc("mask", tec_pkg::OFS_MASK, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 1'b1, e)
    apb(1'b0, tec_pkg::OFS_TSTAMP, 32'h0);
    t0 = q;
    repeat (1000) @(posedge sys_clk);
    apb(1'b0, tec_pkg::OFS_TSTAMP, 32'h0);
    d = q - t0;
    `CHK("ts_rate", 1'b1, d >= 480 && d <= 484)
    $display("test reset done");
    apb(1'b1, tec_pkg::OFS_EXPOSE, 32'ha);
    apb(1'b1, tec_pkg::OFS_READOUT, 32'h14);
    apb(1'b1, tec_pkg::OFS_TIMER, 32'h3);
    apb(1'b1, tec_pkg::OFS_MASK, 32'h1ff);
    apb(1'b1, tec_pkg::OFS_CTRL, 32'h0a);
    tec_trig_source_i.link_pulse(3);
    wt(0, 1'b1, 10);
    `CHK("link_start", 1'b1, n < 4)
    `CHK("wait_low", 1'b0, awaiting_trigger)
    `CHK("timer_on", 1'b1, aux_timer_active)
    wt(0, 1'b0, 2000);
    n1 = n;
    `CHK("exp_len", 1'b1, n > 1120 && n < 1400)
    `CHK("xfer", 1'b1, transfer_active)
    `CHK("timer_off", 1'b0, aux_timer_active)
    repeat (1300) @(posedge sys_clk);
    apb(1'b0, tec_pkg::OFS_STATUS, 32'h0);
    `CHK("events", 9'h1ed, q[8:0])
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, tec_pkg::OFS_EVTS + 8'(4 * tec_pkg::EV_EBEG), 32'h0);
    t0 = q;
    apb(1'b0, tec_pkg::OFS_EVTS + 8'(4 * tec_pkg::EV_EEND), 32'h0);
    d = (q - t0) * 100;
    `CHK("ts_gap", 1'b1, d > n1 * 48 - 400 && d < n1 * 48 + 400)
    repeat (2600) @(posedge sys_clk);
    apb(1'b1, tec_pkg::OFS_STATUS, 32'h1ff);
    rdc("status_clr", tec_pkg::OFS_STATUS, 32'h0);
    `CHK("irq_clr", 1'b0, irq)
    $display("test link trigger done");
    apb(1'b1, tec_pkg::OFS_MASK, 32'(1 << tec_pkg::EV_EBEG));
    apb(1'b1, tec_pkg::OFS_DELAY, 32'h2);
    apb(1'b1, tec_pkg::OFS_READOUT, 32'h64);
    apb(1'b1, tec_pkg::OFS_CTRL, 32'h09);
    apb(1'b1, tec_pkg::OFS_SWTRIG, 32'h1);
    wt(0, 1'b1, 1000);
    `CHK("delay", 1'b1, n >= 125 && n <= 400)
    wt(1, 1'b1, 1400);
    `CHK("notify", 1'b1, n >= 1240 && n <= 1262)
    wt(0, 1'b0, 2000);
    `CHK("exp_done", 1'b1, n < 2000)
    $display("test delay and notify done");
    apb(1'b1, tec_pkg::OFS_DELAY, 32'h0);
    apb(1'b1, tec_pkg::OFS_STATUS, 32'h1ff);
    apb(1'b1, tec_pkg::OFS_SWTRIG, 32'h1);
    wt(0, 1'b1, 40);
    `CHK("no_exp", 1'b1, n == 40)
    repeat (1300) @(posedge sys_clk);
    apb(1'b0, tec_pkg::OFS_STATUS, 32'h0);
    `CHK("rejected", 2'h2, q[1:0])
    $display("test readout refusal done");
    repeat (13000) @(posedge sys_clk);
    apb(1'b1, tec_pkg::OFS_CTRL, 32'h0c);
    tec_trig_source_i.line_set(1'b1);
    repeat (4) @(posedge sys_clk);
    tec_trig_source_i.line_set(1'b0);
    wt(0, 1'b1, 40);
    `CHK("glitch", 1'b1, n == 40)
    tec_trig_source_i.line_set(1'b1);
    wt(0, 1'b1, 40);
    n1 = n;
    `CHK("filter_lat", 1'b1, n1 >= 12 && n1 <= 20)
    repeat (300) @(posedge sys_clk);
    tec_trig_source_i.line_set(1'b0);
    wt(0, 1'b0, 100);
    `CHK("level_tail", 1'b1, n - n1 >= 14 && n - n1 <= 18)
    $display("test level mode done");
    tally_and_finish();
  end
endmodule : test_trigger_exposure_event_control
`default_nettype wire
